// *** core/uat_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  asynchronous timer control block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef UAT_REGS_SVH
`define UAT_REGS_SVH

// ============================================================
// Offsets (data space) and I/O alias
`define UAT_IO_BASE         8'h20
`define UAT_OFF_GEN_CTRL    8'h43
`define UAT_OFF_STATUS      8'hB6
`define UAT_OFF_COUNT       8'hB2
`define UAT_OFF_CMP_A       8'hB3
`define UAT_OFF_CMP_B       8'hB4
`define UAT_OFF_CTRL_A      8'hBA
`define UAT_OFF_CTRL_B      8'hBB

// ============================================================
// General timer control fields
`define UAT_GC_SYNC_HOLD    7
`define UAT_GC_PSR_ASYNC    1
`define UAT_GC_PSR_SHARED   0
`define UAT_GC_RESET        8'h00

// ============================================================
// Asynchronous status fields
`define UAT_ST_EXT_CLK      6
`define UAT_ST_ASYNC_SEL    5
`define UAT_ST_RESET        8'h00
`define UAT_DATA_RESET      8'h00

// ============================================================
// Timing
`define UAT_SYNC_STAGES     2

`endif

// *** core/uat_pkg.sv ***
/*
  Types shared by the asynchronous timer control block.
  Assumes nothing of its surroundings.
*/
package uat_pkg;

  typedef logic [7:0] uat_byte_t;

  // Slot index equals the busy bit position in the status register
  typedef enum logic [2:0] {
    UAT_SLOT_CTRL_B = 3'h0,
    UAT_SLOT_CTRL_A = 3'h1,
    UAT_SLOT_CMP_B  = 3'h2,
    UAT_SLOT_CMP_A  = 3'h3,
    UAT_SLOT_COUNT  = 3'h4
  } uat_slot_e;

endpackage

// *** core/uat_tick_sync.sv ***
/*
  Brings the asynchronous timer clock level into the system clock domain
  and gives a one-cycle pulse per rising edge.
  Assumes the timer clock runs well below half the system clock.
*/
`timescale 1ns/1ps
`include "uat_regs.svh"

module uat_tick_sync #(
  parameter int STAGES = `UAT_SYNC_STAGES
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Timer clock level and edge pulse
  input  wire logic timer_clk_level,
  output logic      tick
);

  // Elaboration check on the chain length
  if (STAGES < 2) begin : g_bad_stages
    $error("uat_tick_sync: STAGES must be at least 2");
  end

  logic [STAGES-1:0] sync_chain;
  logic              sync_last;

  // ============================================================
  // Synchroniser chain, then edge detect on the settled stages
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_chain <= '0;
      sync_last  <= 1'b0;
    end else begin
      sync_chain <= {sync_chain[STAGES-2:0], timer_clk_level};
      sync_last  <= sync_chain[STAGES-1];
    end
  end

  assign tick = sync_chain[STAGES-1] & ~sync_last;

endmodule // uat_tick_sync

// *** core/uat_ctrl.sv ***
/*
  Asynchronous timer register front end with update-busy tracking and the
  general timer control register holding both prescaler resets.
  Assumes a processor access port synchronous to clk_sys and the timer
  clock arriving as a plain level input.
*/
// Operation
// - Async write to compare B sets its busy bit until moved across.
// - Async write to control A sets its busy bit until moved across.
// - Async write to control B sets its busy bit until moved across.
// - General control answers at data offset and at I/O offset 0x20 lower.
// - Sync hold set keeps written prescaler reset bits asserted.
// - Sync hold cleared clears both prescaler resets together.
// - Async prescaler reset bit resets prescaler; cleared at once when synchronous.
// - In async mode the bit stays one until the async reset completes.
// - Async prescaler reset bit is not auto-cleared during sync hold.
// - Shared prescaler reset pulses once unless sync hold is set.
// - Clock select bit picks I/O clock or external oscillator.
// - Async write to counter sets its busy bit until loaded.
// - Async write to compare A sets its busy bit until moved across.
`timescale 1ns/1ps
`include "uat_regs.svh"

module uat_ctrl #(
  parameter int DATA_W = 8,
  parameter int SLOTS  = 5
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Processor register access
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_io_space,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire uat_pkg::uat_byte_t reg_wdata,
  output uat_pkg::uat_byte_t     reg_rdata,
  // Timer clock level from the oscillator
  input  wire logic              timer_clk_level,
  // Timer-domain register values
  output uat_pkg::uat_byte_t     async_timer_count,
  output uat_pkg::uat_byte_t     async_compare_a,
  output uat_pkg::uat_byte_t     async_compare_b,
  output uat_pkg::uat_byte_t     async_timer_ctrl_a,
  output uat_pkg::uat_byte_t     async_timer_ctrl_b,
  // Clock selection and prescaler resets
  output logic                   async_clock_select,
  output logic                   ext_clock_enable,
  output logic                   async_prescaler_reset,
  output logic                   shared_prescaler_reset,
  output logic                   timer_sync_hold
);
  import uat_pkg::*;

  // Elaboration checks on the parameters
  if (DATA_W != 8) begin : g_bad_width
    $error("uat_ctrl: DATA_W must be 8");
  end
  if (SLOTS != 5) begin : g_bad_slots
    $error("uat_ctrl: SLOTS must be 5");
  end

  logic [7:0]       eff_addr;
  logic             addr_ok;
  logic             hit_gen;
  logic             hit_stat;
  logic [SLOTS-1:0] hit_slot;
  logic             tick;
  logic [SLOTS-1:0] busy;
  uat_byte_t        temp_val [SLOTS];
  uat_byte_t        dest_val [SLOTS];
  logic             wr_gen;

  // ============================================================
  // Timer clock edge detection
  uat_tick_sync #(.STAGES(`UAT_SYNC_STAGES)) u_tick (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .timer_clk_level (timer_clk_level),
    .tick            (tick)
  );

  // ============================================================
  // Address decode, I/O space mapped 0x20 lower
  always_comb begin
    addr_ok  = 1'b1;
    eff_addr = reg_addr;
    if (reg_io_space) begin
      addr_ok  = (reg_addr[7:6] == 2'h0);
      eff_addr = 8'(reg_addr + `UAT_IO_BASE);
    end
    hit_gen  = 1'b0;
    hit_stat = 1'b0;
    hit_slot = '0;
    if (!addr_ok) begin
      hit_gen = 1'b0;
    end else if (eff_addr == `UAT_OFF_GEN_CTRL) begin
      hit_gen = 1'b1;
    end else if (eff_addr == `UAT_OFF_STATUS) begin
      hit_stat = 1'b1;
    end else if (eff_addr == `UAT_OFF_COUNT) begin
      hit_slot[UAT_SLOT_COUNT] = 1'b1;
    end else if (eff_addr == `UAT_OFF_CMP_A) begin
      hit_slot[UAT_SLOT_CMP_A] = 1'b1;
    end else if (eff_addr == `UAT_OFF_CMP_B) begin
      hit_slot[UAT_SLOT_CMP_B] = 1'b1;
    end else if (eff_addr == `UAT_OFF_CTRL_A) begin
      hit_slot[UAT_SLOT_CTRL_A] = 1'b1;
    end else if (eff_addr == `UAT_OFF_CTRL_B) begin
      hit_slot[UAT_SLOT_CTRL_B] = 1'b1;
    end
  end

  assign wr_gen = reg_wr & hit_gen;

  // ============================================================
  // Temporary storage, busy flags and timer-domain values
  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        busy[i]     <= 1'b0;
        temp_val[i] <= `UAT_DATA_RESET;
        dest_val[i] <= `UAT_DATA_RESET;
      end else begin
        if (reg_wr && hit_slot[i]) begin
          temp_val[i] <= reg_wdata;
        end
        if (async_clock_select) begin
          if (tick && busy[i]) begin
            dest_val[i] <= temp_val[i];
          end
          // A new write in the commit cycle keeps the flag set
          busy[i] <= (reg_wr & hit_slot[i]) | (busy[i] & ~tick);
        end else begin
          if (reg_wr && hit_slot[i]) begin
            dest_val[i] <= reg_wdata;
          end
          busy[i] <= 1'b0;
        end
      end
    end
  end

  assign async_timer_count  = dest_val[UAT_SLOT_COUNT];
  assign async_compare_a    = dest_val[UAT_SLOT_CMP_A];
  assign async_compare_b    = dest_val[UAT_SLOT_CMP_B];
  assign async_timer_ctrl_a = dest_val[UAT_SLOT_CTRL_A];
  assign async_timer_ctrl_b = dest_val[UAT_SLOT_CTRL_B];

  // ============================================================
  // Status register: clock select and external clock enable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      async_clock_select <= 1'b0;
      ext_clock_enable   <= 1'b0;
    end else if (reg_wr && hit_stat) begin
      async_clock_select <= reg_wdata[`UAT_ST_ASYNC_SEL];
      ext_clock_enable   <= reg_wdata[`UAT_ST_EXT_CLK];
    end
  end

  // ============================================================
  // General control: sync hold and prescaler resets
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_sync_hold        <= 1'b0;
      async_prescaler_reset  <= 1'b0;
      shared_prescaler_reset <= 1'b0;
    end else if (wr_gen) begin
      timer_sync_hold <= reg_wdata[`UAT_GC_SYNC_HOLD];
      if (timer_sync_hold && !reg_wdata[`UAT_GC_SYNC_HOLD]) begin
        async_prescaler_reset  <= 1'b0;
        shared_prescaler_reset <= 1'b0;
      end else begin
        async_prescaler_reset  <= reg_wdata[`UAT_GC_PSR_ASYNC];
        shared_prescaler_reset <= reg_wdata[`UAT_GC_PSR_SHARED];
      end
    end else if (!timer_sync_hold) begin
      shared_prescaler_reset <= 1'b0;
      if (!async_clock_select || tick) begin
        async_prescaler_reset <= 1'b0;
      end
    end
  end

  // ============================================================
  // Read data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= `UAT_DATA_RESET;
    end else if (reg_rd) begin
      reg_rdata <= `UAT_DATA_RESET;
      if (hit_gen) begin
        reg_rdata <= {timer_sync_hold, 5'h00, async_prescaler_reset,
                      shared_prescaler_reset};
      end else if (hit_stat) begin
        reg_rdata <= {1'b0, ext_clock_enable, async_clock_select, busy};
      end else begin
        for (int k = 0; k < SLOTS; k++) begin
          if (hit_slot[k]) reg_rdata <= dest_val[k];
        end
      end
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_cmp_b_busy: assert property (
    async_clock_select && reg_wr && hit_slot[UAT_SLOT_CMP_B]
      |=> busy[UAT_SLOT_CMP_B] && $stable(async_compare_b))
    else $error("compare B busy not set on async write");

  a_ctrl_a_busy: assert property (
    async_clock_select && reg_wr && hit_slot[UAT_SLOT_CTRL_A] |=> busy[UAT_SLOT_CTRL_A])
    else $error("control A busy not set on async write");

  a_ctrl_b_busy: assert property (
    async_clock_select && reg_wr && hit_slot[UAT_SLOT_CTRL_B] |=> busy[UAT_SLOT_CTRL_B])
    else $error("control B busy not set on async write");

  a_count_commit: assert property (
    async_clock_select && busy[UAT_SLOT_COUNT] && tick && !(reg_wr && hit_slot[UAT_SLOT_COUNT])
      |=> !busy[UAT_SLOT_COUNT] && async_timer_count == $past(temp_val[UAT_SLOT_COUNT]))
    else $error("counter commit or busy clear wrong");

  a_cmp_a_wait: assert property (
    async_clock_select && busy[UAT_SLOT_CMP_A] && !tick |=> busy[UAT_SLOT_CMP_A])
    else $error("compare A busy cleared without timer edge");

  a_io_alias_write: assert property (
    reg_wr && reg_io_space && reg_addr == 8'h23 && reg_wdata[7] |=> timer_sync_hold)
    else $error("I/O alias write missed general control");

  a_hold_keeps_psr: assert property (
    timer_sync_hold && !wr_gen |=> $stable(async_prescaler_reset)
      && $stable(shared_prescaler_reset))
    else $error("prescaler reset changed during sync hold");

  a_release_clears: assert property (
    wr_gen && timer_sync_hold && !reg_wdata[7]
      |=> !async_prescaler_reset && !shared_prescaler_reset)
    else $error("release did not clear prescaler resets");

  a_shared_pulse: assert property (
    shared_prescaler_reset && !timer_sync_hold && !wr_gen |=> !shared_prescaler_reset)
    else $error("shared prescaler reset not auto-cleared");

  a_async_psr_sync: assert property (
    async_prescaler_reset && !async_clock_select && !timer_sync_hold && !wr_gen
      |=> !async_prescaler_reset)
    else $error("async prescaler reset not cleared in sync mode");

  a_async_psr_wait: assert property (
    async_prescaler_reset && async_clock_select && !tick && !wr_gen |=> async_prescaler_reset)
    else $error("async prescaler reset cleared before timer edge");

  a_gen_reserved: assert property (
    reg_rd && hit_gen |=> reg_rdata[6:2] == 5'h00)
    else $error("reserved general control bits not zero");

endmodule // uat_ctrl

// *** dv/test_uat_ctrl.sv ***
/*
  Self-checking bench for the asynchronous timer control block.
  Assumes the design files under core/ are compiled before this file.
*/
`timescale 1ns/1ps

module test_uat_ctrl;
  import uat_pkg::*;
  // ============================================================
  // Signals
  typedef struct {logic [7:0] a; logic io; uat_byte_t d; uat_byte_t e;} uat_row_s;
  logic       clk_sys, sys_rst, reg_io_space, reg_wr, reg_rd, timer_clk_level;
  logic [7:0] reg_addr;
  uat_byte_t  reg_wdata, reg_rdata, cnt, cmp_a, cmp_b, ctl_a, ctl_b, rv;
  logic       sel, ext_en, psr_async, psr_shared, hold;
  int         miscompares, checked, cyc;
  uat_row_s   rows[10];
  logic [7:0] slot_addr[5];

  // ============================================================
  // Device under test
  uat_ctrl u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_io_space(reg_io_space), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_clk_level(timer_clk_level),
    .async_timer_count(cnt), .async_compare_a(cmp_a), .async_compare_b(cmp_b),
    .async_timer_ctrl_a(ctl_a), .async_timer_ctrl_b(ctl_b),
    .async_clock_select(sel), .ext_clock_enable(ext_en),
    .async_prescaler_reset(psr_async), .shared_prescaler_reset(psr_shared),
    .timer_sync_hold(hold));

  // ============================================================
  // Clock and timeout
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      test_done();
    end
  end

  // ============================================================
  // Tasks
  task automatic chk(string name, uat_byte_t seen, uat_byte_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic io, uat_byte_t d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_io_space = io;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic io, output uat_byte_t d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_io_space = io;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // One timer clock period, long enough for the synchroniser and commit
  task automatic tick();
    @(negedge clk_sys);
    timer_clk_level = 1'b1;
    repeat (6) @(negedge clk_sys);
    timer_clk_level = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask

  function automatic uat_byte_t slot_val(logic [7:0] a);
    case (a)
      8'hB2:   return cnt;
      8'hB3:   return cmp_a;
      8'hB4:   return cmp_b;
      8'hBA:   return ctl_a;
      default: return ctl_b;
    endcase
  endfunction

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ============================================================
  // Main sequence; never rewrites a slot while its busy bit is set
  initial begin
    {reg_io_space, reg_wr, reg_rd, timer_clk_level} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sys_rst = 1'b1;
    slot_addr = '{8'hBB, 8'hBA, 8'hB4, 8'hB3, 8'hB2};
    rows = '{'{8'hB2, 1'b0, 8'h5A, 8'h5A}, '{8'hB3, 1'b0, 8'hA5, 8'hA5},
             '{8'hB4, 1'b0, 8'h3C, 8'h3C}, '{8'hBA, 1'b0, 8'hC3, 8'hC3},
             '{8'hBB, 1'b0, 8'h0F, 8'h0F}, '{8'h23, 1'b1, 8'h7E, 8'h00},
             '{8'h43, 1'b1, 8'h81, 8'h00}, '{8'h50, 1'b0, 8'hFF, 8'h00},
             '{8'hB6, 1'b0, 8'h5F, 8'h40}, '{8'hB6, 1'b0, 8'h00, 8'h00}};
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].io, rows[i].d);
      rd(rows[i].a, rows[i].io, rv);
      chk("row readback", rv, rows[i].e);
      if (rows[i].a[7]) begin
        if (rows[i].a != 8'hB6) chk("row port", slot_val(rows[i].a), rows[i].e);
      end
    end
    chk("refused write", {7'h0, hold}, 8'h00);
    $display("test table done");
    wr(8'h23, 1'b1, 8'h83);
    chk("hold", {7'h0, hold}, 8'h01);
    repeat (3) @(negedge clk_sys);
    rd(8'h23, 1'b1, rv);
    chk("ctrl io read", rv, 8'h83);
    chk("psr both", {6'h0, psr_async, psr_shared}, 8'h03);
    wr(8'h43, 1'b0, 8'h03);
    chk("release", {5'h0, hold, psr_async, psr_shared}, 8'h00);
    wr(8'h43, 1'b0, 8'h01);
    chk("shared pulse", {7'h0, psr_shared}, 8'h01);
    @(negedge clk_sys);
    chk("shared clear", {7'h0, psr_shared}, 8'h00);
    wr(8'h43, 1'b0, 8'h02);
    chk("async pulse", {7'h0, psr_async}, 8'h01);
    @(negedge clk_sys);
    chk("async clear", {7'h0, psr_async}, 8'h00);
    $display("test hold done");
    wr(8'hB6, 1'b0, 8'h40);
    wr(8'h43, 1'b0, 8'h80);
    chk("ext enable", {6'h0, ext_en, hold}, 8'h03);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk("reset ports", {5'h0, ext_en, sel, hold}, 8'h00);
    rd(8'hB3, 1'b0, rv);
    chk("reset cmp a", rv, 8'h00);
    rd(8'h43, 1'b0, rv);
    chk("reset ctrl", rv, 8'h00);
    $display("test reset done");
    wr(8'hB6, 1'b0, 8'h20);
    chk("select", {7'h0, sel}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(slot_addr[i], 1'b0, 8'h90 + 8'(i));
      chk("before commit", slot_val(slot_addr[i]), 8'h00);
      rd(8'hB6, 1'b0, rv);
      chk("busy set", rv, 8'h20 | (8'h01 << i));
      tick();
      chk("committed", slot_val(slot_addr[i]), 8'h90 + 8'(i));
      rd(8'hB6, 1'b0, rv);
      chk("busy clear", rv, 8'h20);
    end
    wr(8'h43, 1'b0, 8'h02);
    repeat (4) @(negedge clk_sys);
    rd(8'h43, 1'b0, rv);
    chk("async psr held", rv, 8'h02);
    tick();
    chk("async psr done", {7'h0, psr_async}, 8'h00);
    wr(8'h43, 1'b0, 8'h82);
    tick();
    chk("psr in hold", {7'h0, psr_async}, 8'h01);
    wr(8'h43, 1'b0, 8'h00);
    chk("hold left", {6'h0, hold, psr_async}, 8'h00);
    $display("test async done");
    test_done();
  end
endmodule // test_uat_ctrl
